/* hw/brake_and_stop_supervisor.sv */
// Brake output supervision and controlled-stop supervisor with Avalon-MM registers.
// Overview of operation
// - Brake current is measured while the brake is released; flags derive from it.
// - Current above 3.3 A raises the overcurrent error.
// - Current below 100 mA raises only a warning, never the safe state.
// - An undercurrent may take up to 100 ms before it is reported.
// - An undercurrent never removes torque by itself; the drive side must act.
// - Brake supply outside 24 V +-10 % sets status bit 0 and an error.
// - While released, both switches are pulsed off at the set interval and read back.
// - Pulse test finds shorts to supply or ground and enters the safe state.
// - Each brake output diagnosis finishes within 6 ms.
// - With coupling on, brake closes the moment a stop reaches torque off.
// - Measurement enable gates current checks; overcurrent then forces the safe state.
// - Controlled stop offers ramp-monitored and timed variants, selectable singly or together.
// - Eight limit sets exist; an index input selects the active one.
// - Stop is left only with both channels energised or via the safe bus.
// - Status bit 3 shows the controlled stop as active.
// - Stop activation and release take effect within 4 ms.
// - Only the block's own parameters shape the stop behaviour.
// - Each set holds type, deceleration, tolerances, window and delay; deceleration resets nonzero.
// - A stop keeps torque while braking and removes it when its variant finishes, or at once with none selected.
// - Status bit 2 shows the brake open, possible only once brake control allows.
// - Ramp variant removes torque when speed leaves tolerance longer than the window.
// - Timed variant removes torque when its delay expires, without checking speed.
// - With both variants, whichever finishes first removes torque.
module brake_and_stop_supervisor #(
   parameter int UC_CYC   = brake_stop_pkg::UC_CYCLES,
   parameter int DIAG_CYC = brake_stop_pkg::DIAG_CYCLES,
   parameter int TICK_CYC = brake_stop_pkg::TICK_CYCLES
) (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic [8:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   input  wire logic        ch_a_i,
   input  wire logic        ch_b_i,
   input  wire logic        bus_stop_i,
   input  wire logic [2:0]  stop_index_i,
   input  wire logic [15:0] speed_i,
   input  wire logic        brake_release_i,
   input  wire logic [15:0] current_ma_i,
   input  wire logic [15:0] supply_mv_i,
   input  wire logic        hs_fb_i,
   input  wire logic        ls_fb_i,
   output logic             brake_hs_o,
   output logic             brake_ls_o,
   output logic             torque_off_o,
   output logic             stop_active_o
);
   stop_if sq ();

   logic [3:0]                sync1;
   logic [3:0]                sync2;
   logic [2:0]                ctrl;
   logic [15:0]               pt_period;
   logic [15:0]               params [brake_stop_pkg::NUM_SETS][brake_stop_pkg::NUM_FIELDS];
   logic [brake_stop_pkg::ERR_W-1:0] err;
   logic [brake_stop_pkg::ERR_W-1:0] set_ev;
   logic [brake_stop_pkg::ERR_W-1:0] clr;
   logic [5:0]                status;
   logic [31:0]               next_rdata;
   logic [16:0]               tick_cnt;
   logic                      tick;
   logic [15:0]               iv_cnt;
   logic [11:0]               pulse_cnt;
   logic [16:0]               diag_cnt;
   logic [21:0]               uc_cnt;
   brake_stop_pkg::pt_state_t pt_state;
   logic                      brake_open;
   logic                      sup_bad_r;
   logic                      ch_a;
   logic                      ch_b;
   logic                      fb_hs;
   logic                      fb_ls;
   logic                      wr_go;
   logic                      in_set;
   logic [2:0]                set_idx;
   logic [2:0]                set_fld;
   logic                      safe_state;
   logic                      to_now;
   logic                      open_now;
   logic                      oc_ev;
   logic                      uc_cond;
   logic                      uc_ev;
   logic                      sup_bad;
   logic                      pt_go;
   logic                      pulse_end;
   logic                      pt_fault;

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // The channel and switch feedback pins settle through two flops before any use.
   // The channels reset to energised, so leaving reset is not taken for a stop demand.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sync1 <= 4'hc;
         sync2 <= 4'hc;
      end else begin
         sync1 <= {ch_a_i, ch_b_i, hs_fb_i, ls_fb_i};
         sync2 <= sync1;
      end
   end
   assign {ch_a, ch_b, fb_hs, fb_ls} = sync2;

   // Bus slave: one wait cycle, then the request is taken.
   assign wr_go   = write_i && !waitrequest_o;
   assign set_fld = address_i[4:2];
   assign set_idx = 3'(address_i[8:5] - brake_stop_pkg::SET_BASE_BLK);
   assign in_set  = address_i >= brake_stop_pkg::ADDR_SET_BASE
                    && address_i < brake_stop_pkg::ADDR_SET_END
                    && set_fld < 3'(brake_stop_pkg::NUM_FIELDS)
                    && address_i[1:0] == 2'b00;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         waitrequest_o <= 1'b1;
      end else begin
         waitrequest_o <= !((read_i || write_i) && waitrequest_o);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         readdata_o <= 32'h0000_0000;
      end else if (read_i && waitrequest_o) begin
         readdata_o <= next_rdata;
      end
   end

   always_comb begin
      status = 6'h00;
      status[brake_stop_pkg::ST_SUPPLY]     = sup_bad_r;
      status[brake_stop_pkg::ST_BRAKE_OPEN] = brake_open;
      status[brake_stop_pkg::ST_STOP]       = stop_active_o;
      status[brake_stop_pkg::ST_TORQUE_OFF] = torque_off_o;
      next_rdata = 32'h0000_0000;
      if (in_set) begin
         next_rdata = {16'h0000, params[set_idx][set_fld]};
      end else begin
         unique case (address_i)
            brake_stop_pkg::ADDR_CTRL:      next_rdata = {29'h0, ctrl};
            brake_stop_pkg::ADDR_PT_PERIOD: next_rdata = {16'h0000, pt_period};
            brake_stop_pkg::ADDR_STATUS:    next_rdata = {26'h0, status};
            brake_stop_pkg::ADDR_ERROR:     next_rdata = {27'h0, err};
            default:                        next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctrl      <= brake_stop_pkg::CTRL_RESET;
         pt_period <= brake_stop_pkg::PT_PERIOD_RESET;
      end else if (wr_go && address_i == brake_stop_pkg::ADDR_CTRL) begin
         ctrl <= writedata_i[2:0];
      end else if (wr_go && address_i == brake_stop_pkg::ADDR_PT_PERIOD) begin
         pt_period <= writedata_i[15:0];
      end
   end

   for (genvar g = 0; g < brake_stop_pkg::NUM_SETS; g++) begin : g_set
      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            for (int f = 0; f < brake_stop_pkg::NUM_FIELDS; f++) begin
               params[g][f] <= (f == brake_stop_pkg::F_DECEL) ?
                               brake_stop_pkg::DECEL_RESET : 16'h0000;
            end
         end else if (wr_go && in_set && set_idx == 3'(g)) begin
            params[g][set_fld] <= writedata_i[15:0];
         end
      end
   end

   // Millisecond tick paces the pulse-test interval and the stop timers.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || tick_cnt == 17'(TICK_CYC - 1)) begin
         tick_cnt <= 17'h0;
         tick     <= rst_n_i;
      end else begin
         tick_cnt <= tick_cnt + 17'h1;
         tick     <= 1'b0;
      end
   end

   // Current checks only while released and with measurement enabled.
   assign oc_ev   = ctrl[brake_stop_pkg::CTRL_MEAS] && brake_open
                    && current_ma_i > brake_stop_pkg::OC_LIMIT_MA;
   assign uc_cond = ctrl[brake_stop_pkg::CTRL_MEAS] && brake_open
                    && current_ma_i < brake_stop_pkg::UC_LIMIT_MA;
   assign uc_ev   = uc_cond && uc_cnt == 22'(UC_CYC - 1);
   assign sup_bad = supply_mv_i < brake_stop_pkg::SUPPLY_MIN_MV
                    || supply_mv_i > brake_stop_pkg::SUPPLY_MAX_MV;

   // A slowly rising coil current must stay low for the whole window to count.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || !uc_cond) begin
         uc_cnt <= 22'h0;
      end else if (!uc_ev) begin
         uc_cnt <= uc_cnt + 22'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sup_bad_r <= 1'b0;
      end else begin
         sup_bad_r <= sup_bad;
      end
   end

   // Error flags are write-one-to-clear; a new event wins over the clear.
   always_comb begin
      set_ev = '0;
      set_ev[brake_stop_pkg::ERR_OC]     = oc_ev;
      set_ev[brake_stop_pkg::ERR_UC]     = uc_ev;
      set_ev[brake_stop_pkg::ERR_SUPPLY] = sup_bad;
      set_ev[brake_stop_pkg::ERR_PULSE]  = pt_fault;
      set_ev[brake_stop_pkg::ERR_SAFE]   = oc_ev || pt_fault;
      clr = (wr_go && address_i == brake_stop_pkg::ADDR_ERROR) ?
            writedata_i[brake_stop_pkg::ERR_W-1:0] : '0;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         err <= '0;
      end else begin
         err <= (err & ~clr) | set_ev;
      end
   end
   assign safe_state = err[brake_stop_pkg::ERR_SAFE];

   // Pulse test: both switches read on, high side off, then low side off.
   // Starting at mid-tick gives a switch just turned back on time to read back high.
   assign pt_go     = pt_state == brake_stop_pkg::PT_WAIT && brake_open
                      && iv_cnt != 16'h0 && iv_cnt >= pt_period
                      && tick_cnt == 17'(TICK_CYC / 2);
   assign pulse_end = pulse_cnt == 12'(brake_stop_pkg::PULSE_CYCLES - 1);
   assign pt_fault  = (pt_go && !(fb_hs && fb_ls))
                      || (pt_state == brake_stop_pkg::PT_HS_OFF && pulse_end && fb_hs)
                      || (pt_state == brake_stop_pkg::PT_LS_OFF && pulse_end && fb_ls);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || !brake_open || pt_state != brake_stop_pkg::PT_WAIT) begin
         iv_cnt <= 16'h0;
      end else if (tick && iv_cnt != 16'hffff) begin
         iv_cnt <= iv_cnt + 16'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || pt_state == brake_stop_pkg::PT_WAIT || pulse_end) begin
         pulse_cnt <= 12'h0;
      end else begin
         pulse_cnt <= pulse_cnt + 12'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || pt_state == brake_stop_pkg::PT_WAIT) begin
         diag_cnt <= 17'h0;
      end else begin
         diag_cnt <= diag_cnt + 17'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pt_state <= brake_stop_pkg::PT_WAIT;
      end else begin
         unique case (pt_state)
            brake_stop_pkg::PT_WAIT: begin
               if (pt_go && !pt_fault) pt_state <= brake_stop_pkg::PT_HS_OFF;
            end
            brake_stop_pkg::PT_HS_OFF: begin
               if (!brake_open || (pulse_end && pt_fault)) begin
                  pt_state <= brake_stop_pkg::PT_WAIT;
               end else if (pulse_end) begin
                  pt_state <= brake_stop_pkg::PT_LS_OFF;
               end
            end
            brake_stop_pkg::PT_LS_OFF: begin
               if (!brake_open || pulse_end) pt_state <= brake_stop_pkg::PT_WAIT;
            end
            default: pt_state <= brake_stop_pkg::PT_WAIT;
         endcase
      end
   end

   // Controlled stop: demand from the two channels or from the safe bus.
   assign sq.demand    = ctrl[brake_stop_pkg::CTRL_BUS] ? bus_stop_i : !(ch_a && ch_b);
   assign sq.tick      = tick;
   assign sq.speed     = speed_i;
   assign sq.index_req = stop_index_i;
   assign sq.stype     = params[sq.sel_index][brake_stop_pkg::F_TYPE];
   assign sq.decel     = params[sq.sel_index][brake_stop_pkg::F_DECEL];
   assign sq.tol_neg   = params[sq.sel_index][brake_stop_pkg::F_TOL_NEG];
   assign sq.tol_pos   = params[sq.sel_index][brake_stop_pkg::F_TOL_POS];
   assign sq.window    = params[sq.sel_index][brake_stop_pkg::F_WINDOW];
   assign sq.t_time    = params[sq.sel_index][brake_stop_pkg::F_T_TIME];

   stop_sequencer u_seq (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .s       (sq.seq)
   );

   // Torque removal and brake closing switch together on a safe state, and on a stop only with coupling on.
   assign to_now   = safe_state || sq.torque_off;
   assign open_now = brake_release_i && !safe_state
                     && !(ctrl[brake_stop_pkg::CTRL_COUPLE] && sq.torque_off);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         torque_off_o  <= 1'b0;
         stop_active_o <= 1'b0;
         brake_open    <= 1'b0;
         brake_hs_o    <= 1'b0;
         brake_ls_o    <= 1'b0;
      end else begin
         torque_off_o  <= to_now;
         stop_active_o <= sq.active;
         brake_open    <= open_now;
         brake_hs_o    <= open_now && pt_state != brake_stop_pkg::PT_HS_OFF;
         brake_ls_o    <= open_now && pt_state != brake_stop_pkg::PT_LS_OFF;
      end
   end

   a_overcurrent_flag: assert property (oc_ev |=> err[brake_stop_pkg::ERR_OC])
      else $error("overcurrent not flagged");
   a_overcurrent_safe: assert property (oc_ev |-> ##2 (!brake_hs_o && torque_off_o))
      else $error("overcurrent did not reach safe state");
   a_undercurrent_warn: assert property (uc_ev && !oc_ev && !pt_fault && !safe_state
      |=> err[brake_stop_pkg::ERR_UC] && !safe_state) else $error("undercurrent misreported");
   a_no_auto_torque: assert property (!safe_state && !sq.torque_off |=> !torque_off_o)
      else $error("torque removed without cause");
   a_supply_band: assert property (sup_bad |=> sup_bad_r && err[brake_stop_pkg::ERR_SUPPLY])
      else $error("supply fault not reported");
   a_pulse_fault: assert property (pt_fault |=> safe_state ##1 !brake_hs_o && !brake_ls_o)
      else $error("pulse fault did not close brake");
   a_diag_bound: assert property (pt_state != brake_stop_pkg::PT_WAIT
      |-> diag_cnt < 17'(DIAG_CYC)) else $error("diagnosis too long");
   a_coupled_brake: assert property (ctrl[brake_stop_pkg::CTRL_COUPLE] && sq.torque_off
      |=> torque_off_o && !brake_hs_o && !brake_ls_o) else $error("coupled brake not closed");
   a_stop_status: assert property (!sq.active && sq.demand |=> ##1 stop_active_o)
      else $error("stop activation late");
endmodule

/* hw/brake_stop_pkg.sv */
// Shared constants and types for the brake and controlled-stop supervisor.
package brake_stop_pkg;
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          UC_TIME_MS      = 100;
   localparam int          UC_CYCLES       = UC_TIME_MS * (CLK_HZ / 1000);
   localparam int          DIAG_TIME_MS    = 6;
   localparam int          DIAG_CYCLES     = DIAG_TIME_MS * (CLK_HZ / 1000);
   localparam int          TICK_TIME_US    = 1000;
   localparam int          TICK_CYCLES     = TICK_TIME_US * (CLK_HZ / 1_000_000);
   localparam int          PULSE_TIME_US   = 100;
   localparam int          PULSE_CYCLES    = PULSE_TIME_US * (CLK_HZ / 1_000_000);
   localparam logic [15:0] OC_LIMIT_MA     = 16'h0ce4;
   localparam logic [15:0] UC_LIMIT_MA     = 16'h0064;
   localparam int          SUPPLY_NOM_MV   = 24000;
   localparam int          SUPPLY_TOL_PCT  = 10;
   localparam logic [15:0] SUPPLY_MIN_MV   = 16'(SUPPLY_NOM_MV * (100 - SUPPLY_TOL_PCT) / 100);
   localparam logic [15:0] SUPPLY_MAX_MV   = 16'(SUPPLY_NOM_MV * (100 + SUPPLY_TOL_PCT) / 100);
   localparam logic [8:0]  ADDR_CTRL       = 9'h000;
   localparam logic [8:0]  ADDR_PT_PERIOD  = 9'h004;
   localparam logic [8:0]  ADDR_STATUS     = 9'h008;
   localparam logic [8:0]  ADDR_ERROR      = 9'h00c;
   localparam logic [8:0]  ADDR_SET_BASE   = 9'h040;
   localparam logic [8:0]  ADDR_SET_END    = 9'h140;
   localparam logic [3:0]  SET_BASE_BLK    = 4'h2;
   localparam int          CTRL_COUPLE     = 0;
   localparam int          CTRL_MEAS       = 1;
   localparam int          CTRL_BUS        = 2;
   localparam logic [2:0]  CTRL_RESET      = 3'h2;
   localparam logic [15:0] PT_PERIOD_RESET = 16'h03e8;
   localparam int          ST_SUPPLY       = 0;
   localparam int          ST_BRAKE_OPEN   = 2;
   localparam int          ST_STOP         = 3;
   localparam int          ST_TORQUE_OFF   = 4;
   localparam int          ERR_OC          = 0;
   localparam int          ERR_UC          = 1;
   localparam int          ERR_SUPPLY      = 2;
   localparam int          ERR_PULSE       = 3;
   localparam int          ERR_SAFE        = 4;
   localparam int          ERR_W           = 5;
   localparam int          NUM_SETS        = 8;
   localparam int          NUM_FIELDS      = 6;
   localparam int          F_TYPE          = 0;
   localparam int          F_DECEL         = 1;
   localparam int          F_TOL_NEG       = 2;
   localparam int          F_TOL_POS       = 3;
   localparam int          F_WINDOW        = 4;
   localparam int          F_T_TIME        = 5;
   localparam logic [15:0] DECEL_RESET     = 16'h0001;
   localparam int          TYPE_RAMP       = 0;
   localparam int          TYPE_TIMED      = 1;
   typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_RUN = 2'b01, SEQ_HALT = 2'b10} seq_state_t;
   typedef enum logic [1:0] {PT_WAIT = 2'b00, PT_HS_OFF = 2'b01, PT_LS_OFF = 2'b10} pt_state_t;
endpackage

/* hw/stop_if.sv */
// Signals between the supervisor and its controlled-stop sequencer.
interface stop_if;
   logic               demand;
   logic               tick;
   logic signed [15:0] speed;
   logic [2:0]         index_req;
   logic [2:0]         sel_index;
   logic [15:0]        stype;
   logic [15:0]        decel;
   logic [15:0]        tol_neg;
   logic [15:0]        tol_pos;
   logic [15:0]        window;
   logic [15:0]        t_time;
   logic               active;
   logic               torque_off;
   modport seq (input demand, tick, speed, index_req, stype, decel, tol_neg, tol_pos,
                window, t_time, output sel_index, active, torque_off);
   modport ctl (output demand, tick, speed, index_req, stype, decel, tol_neg, tol_pos,
                window, t_time, input sel_index, active, torque_off);
endinterface

/* hw/stop_sequencer.sv */
// Controlled-stop sequencer with ramp-monitored and timed variants.
module stop_sequencer (
   input wire logic clock_i,
   input wire logic rst_n_i,
   stop_if.seq      s
);
   brake_stop_pkg::seq_state_t state;
   logic [2:0]  idx;
   logic [15:0] mag;
   logic [15:0] elapsed;
   logic [15:0] env;
   logic [15:0] dev;
   logic [16:0] env_hi;
   logic [16:0] mag_lo;
   logic        outside;
   logic        ramp_done;
   logic        timed_done;
   logic        stop_done;

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   assign mag     = s.speed[15] ? 16'(-s.speed) : 16'(s.speed);
   assign env_hi  = {1'b0, env} + {1'b0, s.tol_pos};
   assign mag_lo  = {1'b0, mag} + {1'b0, s.tol_neg};
   assign outside = ({1'b0, mag} > env_hi) || (mag_lo < {1'b0, env});
   assign ramp_done  = s.stype[brake_stop_pkg::TYPE_RAMP]
                       && (dev > s.window || mag == 16'h0000);
   assign timed_done = s.stype[brake_stop_pkg::TYPE_TIMED] && elapsed >= s.t_time;
   // With no variant selected the stop fails safe at once.
   assign stop_done  = ramp_done || timed_done
                       || s.stype[1:0] == 2'b00;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state <= brake_stop_pkg::SEQ_IDLE;
      end else begin
         unique case (state)
            brake_stop_pkg::SEQ_IDLE: if (s.demand) state <= brake_stop_pkg::SEQ_RUN;
            brake_stop_pkg::SEQ_RUN: begin
               if (!s.demand) begin
                  state <= brake_stop_pkg::SEQ_IDLE;
               end else if (stop_done) begin
                  state <= brake_stop_pkg::SEQ_HALT;
               end
            end
            brake_stop_pkg::SEQ_HALT: if (!s.demand) state <= brake_stop_pkg::SEQ_IDLE;
            default: state <= brake_stop_pkg::SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         idx <= 3'h0;
      end else if (state == brake_stop_pkg::SEQ_IDLE && s.demand) begin
         idx <= s.index_req;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || state == brake_stop_pkg::SEQ_IDLE) begin
         env     <= rst_n_i ? mag : 16'h0000;
         elapsed <= 16'h0000;
         dev     <= 16'h0000;
      end else if (s.tick) begin
         elapsed <= elapsed + 16'(elapsed != 16'hffff);
         env     <= (env > s.decel) ? env - s.decel : 16'h0000;
         if (outside) begin
            dev <= dev + 16'(dev != 16'hffff);
         end else if (dev != 16'h0000) begin
            dev <= dev - 16'h0001;
         end
      end
   end

   assign s.sel_index  = idx;
   assign s.active     = state != brake_stop_pkg::SEQ_IDLE;
   assign s.torque_off = state == brake_stop_pkg::SEQ_HALT;

   a_index_held: assert property ((state != brake_stop_pkg::SEQ_IDLE) ##1
      (state != brake_stop_pkg::SEQ_IDLE) |-> $stable(idx)) else $error("stop index moved");
   a_timed_expiry: assert property (state == brake_stop_pkg::SEQ_RUN && s.demand
      && timed_done |=> state == brake_stop_pkg::SEQ_HALT) else $error("timed stop late");
endmodule

/* dv/brake_model.sv */
// Behavioural brake coil with switch readback, standing behind the supervisor.
module brake_model (
   input  wire logic        clock_i,
   input  wire logic        hs_i,
   input  wire logic        ls_i,
   input  wire logic [15:0] load_ma_i,
   output logic      [15:0] current_ma_o,
   output logic             hs_fb_o,
   output logic             ls_fb_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // The freewheel path keeps coil current flowing while one switch is pulsed off.
   always_ff @(posedge clock_i) begin
      hs_fb_o      <= hs_i;
      ls_fb_o      <= ls_i;
      current_ma_o <= (hs_i || ls_i) ? load_ma_i : 16'h0000;
   end
endmodule

/* dv/test_brake_and_stop_supervisor.sv */
// Register and pin level bench for the brake and controlled-stop supervisor.
module test_brake_and_stop_supervisor;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_i, rst_n_i = 1'b0, read_i = 1'b0, write_i = 1'b0, ch_a_i = 1'b1;
   logic        release_i = 1'b0, waitrequest_o, hs_o, ls_o, torque_off_o, stop_active_o;
   logic        hs_fb, ls_fb, ch_b_i = 1'b1, bus_stop_i = 1'b0;
   logic [8:0]  address_i = 9'h000;
   logic [2:0]  index_i = 3'h0;
   logic [15:0] load_ma = 16'h01f4, current_ma, supply_i = 16'h5dc0, speed_i = 16'h0000;
   logic [31:0] wdata_i = 32'h00000000, readdata_o, q;
   int          miscompares, comparisons, n;
   brake_and_stop_supervisor #(.UC_CYC(200), .DIAG_CYC(5000), .TICK_CYC(20))
      u_brake_and_stop_supervisor (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(wdata_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .ch_a_i(ch_a_i), .ch_b_i(ch_b_i), .bus_stop_i(bus_stop_i),
      .stop_index_i(index_i), .speed_i(speed_i), .brake_release_i(release_i),
      .current_ma_i(current_ma), .supply_mv_i(supply_i), .hs_fb_i(hs_fb), .ls_fb_i(ls_fb),
      .brake_hs_o(hs_o), .brake_ls_o(ls_o), .torque_off_o(torque_off_o),
      .stop_active_o(stop_active_o));
   brake_model u_brake_model (.clock_i(clock_i), .hs_i(hs_o), .ls_i(ls_o), .load_ma_i(load_ma),
      .current_ma_o(current_ma), .hs_fb_o(hs_fb), .ls_fb_o(ls_fb));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   task automatic results();
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic acc(input logic we, input logic [8:0] a, input logic [31:0] d);
      n = 0;
      address_i <= a;
      wdata_i <= d;
      write_i <= we;
      read_i <= !we;
      do begin
         @(posedge clock_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 50);
      q = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
      chk("answer", n < 50, 1'b1);
      if (n >= 50) results();
      @(posedge clock_i);
   endtask
   task automatic rc(input logic [8:0] a, input logic [31:0] e, input string s);
      acc(1'b0, a, 32'h00000000);
      chk(s, q, e);
   endtask
   task automatic wst(input logic v);
      n = 0;
      while (stop_active_o !== v && n < 200) begin
         @(posedge clock_i);
         n++;
      end
      chk("stop", stop_active_o, v);
      if (n >= 200) results();
   endtask
   initial begin
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      rc(9'h000, 32'h00000002, "ctrl");
      rc(9'h004, 32'h000003e8, "interval");
      rc(9'h0a4, 32'h00000001, "decel");
      rc(9'h134, 32'h00000000, "delay");
      rc(9'h1fc, 32'h00000000, "unmapped");
      acc(1'b1, 9'h008, 32'hffffffff);
      rc(9'h008, 32'h00000000, "status");
      release_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      rc(9'h008, 32'h00000004, "open");
      load_ma <= 16'h0032;
      repeat (260) @(posedge clock_i);
      rc(9'h00c, 32'h00000002, "under");
      chk("torque", torque_off_o, 1'b0);
      load_ma <= 16'h01f4;
      supply_i <= 16'h4e20;
      repeat (10) @(posedge clock_i);
      rc(9'h008, 32'h00000005, "supply");
      rc(9'h00c, 32'h00000006, "supply err");
      supply_i <= 16'h5dc0;
      repeat (10) @(posedge clock_i);
      acc(1'b1, 9'h00c, 32'h00000006);
      rc(9'h00c, 32'h00000000, "cleared");
      acc(1'b1, 9'h004, 32'h00000001);
      repeat (40) @(posedge clock_i);
      chk("pulse hs", hs_o, 1'b0);
      repeat (2000) @(posedge clock_i);
      chk("pulse ls", {hs_o, ls_o}, 2'b10);
      rc(9'h00c, 32'h00000000, "pulse ok");
      acc(1'b1, 9'h000, 32'h00000003);
      acc(1'b1, 9'h080, 32'h00000002);
      acc(1'b1, 9'h094, 32'h00000003);
      index_i <= 3'h2;
      ch_a_i <= 1'b0;
      wst(1'b1);
      rc(9'h008, 32'h0000000c, "active");
      // Set 0 has no variant and would end at once if the index were not latched.
      index_i <= 3'h0;
      repeat (20) @(posedge clock_i);
      chk("torque", torque_off_o, 1'b0);
      repeat (60) @(posedge clock_i);
      chk("torque", torque_off_o, 1'b1);
      chk("coupled", hs_o, 1'b0);
      ch_a_i <= 1'b1;
      wst(1'b0);
      // Set 1 monitors a ramp; a steady speed leaves the shrinking envelope.
      acc(1'b1, 9'h060, 32'h00000001);
      acc(1'b1, 9'h000, 32'h00000007);
      speed_i <= 16'h0064;
      index_i <= 3'h1;
      bus_stop_i <= 1'b1;
      wst(1'b1);
      chk("ramp", torque_off_o, 1'b0);
      repeat (60) @(posedge clock_i);
      chk("ramp", torque_off_o, 1'b1);
      bus_stop_i <= 1'b0;
      wst(1'b0);
      acc(1'b1, 9'h000, 32'h00000003);
      ch_b_i <= 1'b0;
      wst(1'b1);
      ch_b_i <= 1'b1;
      wst(1'b0);
      load_ma <= 16'h0fa0;
      repeat (10) @(posedge clock_i);
      rc(9'h00c, 32'h00000011, "over");
      chk("safe", {torque_off_o, ls_o}, 2'b10);
      results();
   end
endmodule
